// ===== hw/cpc_consts.svh
// charging port control: offsets, field positions, reset values, timing
// assumes inclusion by bare name from every design file that needs it
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

// register byte offsets on the apb bus
`define CPC_REG_CHG_EN    8'h00
`define CPC_REG_LEGACY    8'h04
`define CPC_REG_SIG2A     8'h08
`define CPC_REG_PWR_CFG   8'h0C
`define CPC_REG_PORT_PWR  8'h10
`define CPC_REG_NONREM    8'h14
`define CPC_REG_VID       8'h18
`define CPC_REG_PID       8'h1C
`define CPC_REG_DID       8'h20
`define CPC_REG_STATUS    8'h24

// power config field positions
`define CPC_CFG_SMB       0
`define CPC_CFG_PAIR_LO   1
`define CPC_CFG_PAIR_HI   2
`define CPC_CFG_GANG_PWR  3
`define CPC_CFG_GANG_OCS  4

// identity reset values, arbitrary neutral codes
`define CPC_RST_VID       16'h1234
`define CPC_RST_PID2      16'h0002
`define CPC_RST_PID3      16'h0003
`define CPC_RST_DID       16'h0100

// managed switch addresses start here, one per port
`define CPC_SW_ADDR_BASE  7'h30
`define CPC_NPORT         3'h7

// power states as driven by the hub core
`define CPC_PS_S0         2'h0
`define CPC_PS_S3         2'h1

// smbus quarter bit time and the clock period, both in ns
`define CPC_SMB_QTR_NS    2500
`define CPC_CLK_NS        10
`define CPC_SMB_QTR_CYC   ((`CPC_SMB_QTR_NS) / (`CPC_CLK_NS))
`define CPC_ACK_BIT       4'h8

`endif

// ===== hw/cpc_pkg.sv
// charging port control: shared types
// field widths are written out here; the constants header is not included
package cpc_pkg;

  // probe sequencer states
  typedef enum logic [2:0] {
    CPC_M_IDLE  = 3'b001,
    CPC_M_PROBE = 3'b010,
    CPC_M_WAIT  = 3'b100
  } cpc_main_e_t;

  // smbus bit engine states
  typedef enum logic [3:0] {
    CPC_S_IDLE  = 4'b0001,
    CPC_S_START = 4'b0010,
    CPC_S_BIT   = 4'b0100,
    CPC_S_STOP  = 4'b1000
  } cpc_smb_e_t;

  // per-port charging drive toward the d+/d- analog front end
  typedef struct packed {
    logic [6:0] bc12_en;
    logic [6:0] sig_en;
    logic [6:0] sig_2a;
    logic [6:0] short_emul;
    logic [6:0] legacy_drive;
  } cpc_drive_t;

  // identity values reported by both hub functions
  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid2;
    logic [15:0] pid3;
    logic [15:0] did;
    logic        compound;
  } cpc_ident_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cpc_apb_req_t;

endpackage

// ===== hw/cpc_smb_probe.sv
// smbus master bit engine: start, one address byte with write, ack, stop
// assumes sda_in already synchronised; open-drain enables, high pulls low
`timescale 1ns/10ps
`include "cpc_consts.svh"

module cpc_smb_probe (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // request
  input  wire logic       start,
  input  wire logic [6:0] addr,
  // answer
  output logic            busy,
  output logic            done,
  output logic            acked,
  // bus lines
  input  wire logic       sda_in,
  output logic            scl_oe,
  output logic            sda_oe
);

  typedef struct packed {
    cpc_pkg::cpc_smb_e_t st;
    logic [9:0]          div;
    logic [1:0]          ph;
    logic [3:0]          bitn;
    logic [8:0]          sh;
    logic                scl;
    logic                sda;
    logic                done;
    logic                acked;
  } cpc_smb_state_t;

  cpc_smb_state_t r;
  cpc_smb_state_t next_r;
  logic           tick;

  // quarter-bit enable from the divider; scl is made here, not a second domain
  assign tick = (r.div == 10'(`CPC_SMB_QTR_CYC - 1));

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.div  = tick ? 10'h000 : r.div + 10'h001;
    unique case (r.st)
      cpc_pkg::CPC_S_IDLE: begin
        next_r.div = 10'h000;
        if (start) begin
          next_r.st   = cpc_pkg::CPC_S_START;
          next_r.ph   = 2'h0;
          next_r.bitn = 4'h0;
          next_r.sh   = {addr, 1'b0, 1'b1}; // write bit, then release for ack
        end
      end
      cpc_pkg::CPC_S_START: if (tick) begin
        next_r.ph = r.ph + 2'h1;
        if (r.ph == 2'h1) next_r.sda = 1'b1; // sda falls while scl high
        if (r.ph == 2'h2) next_r.scl = 1'b1;
        if (r.ph == 2'h3) next_r.st = cpc_pkg::CPC_S_BIT;
      end
      cpc_pkg::CPC_S_BIT: if (tick) begin
        next_r.ph = r.ph + 2'h1;
        if (r.ph == 2'h0) next_r.sda = ~r.sh[8];
        if (r.ph == 2'h1) next_r.scl = 1'b0;
        // ack sampled mid-high; a low means a switch answered
        if (r.ph == 2'h2 && r.bitn == `CPC_ACK_BIT) next_r.acked = ~sda_in;
        if (r.ph == 2'h3) begin
          next_r.scl  = 1'b1;
          next_r.sh   = {r.sh[7:0], 1'b1};
          next_r.bitn = r.bitn + 4'h1;
          if (r.bitn == `CPC_ACK_BIT) next_r.st = cpc_pkg::CPC_S_STOP;
        end
      end
      cpc_pkg::CPC_S_STOP: if (tick) begin
        next_r.ph = r.ph + 2'h1;
        if (r.ph == 2'h0) next_r.sda = 1'b1;
        if (r.ph == 2'h1) next_r.scl = 1'b0;
        if (r.ph == 2'h2) next_r.sda = 1'b0; // sda rises while scl high
        if (r.ph == 2'h3) begin
          next_r.st   = cpc_pkg::CPC_S_IDLE;
          next_r.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r    <= '0;
      r.st <= cpc_pkg::CPC_S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign busy   = (r.st != cpc_pkg::CPC_S_IDLE);
  assign done   = r.done;
  assign acked  = r.acked;
  assign scl_oe = r.scl;
  assign sda_oe = r.sda;

endmodule

// ===== hw/cpc_top.sv
// charging port control: apb registers, charging mode drive, switch probe
// assumes hub core gives clock, reset, power state, attach and dcp status
//
// Contract
// RULE1: no ganged power or overcurrent while any port charges.
// RULE2: managed power switch only on charging-enabled ports.
// RULE3: smbus mode turns one pin pair into master clock and data.
// RULE4: smbus mode reads the disable pin as switch alert, active low.
// RULE5: after reset probe address 0x30 plus port for every charging port.
// RULE6: d+/d- handshake is driven here; switch only switches power.
// RULE7: combined mode runs signature, bc1.2, shorted emulation; 1A or 2A.
// RULE8: signature and shorted emulation only on dedicated charging ports.
// RULE9: legacy mode drives data line voltage only on dedicated ports.
// RULE10: disable pin low stops charging; high resumes configured modes.
// RULE11: dynamic disable honoured only with standard power controllers.
// RULE12: software sets charging ports to individual power control.
// RULE13: 1A/2A choice only on charging ports without legacy mode.
// RULE14: legacy mode overrides the signature setting on that port.
// RULE15: software picks the smbus pair only among ports 1-4.
// RULE16: one 16-bit vendor id for both hub functions.
// RULE17: separate 16-bit product ids for each hub function.
// RULE18: one 16-bit release id for both hub functions.
// RULE19: any non-removable port makes both hubs report compound.
// RULE20: smbus host rewrites settings after every power-up.
// RULE21: dynamic charging judged per power state from enable and attach.
`timescale 1ns/10ps
`include "cpc_consts.svh"

module cpc_top (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // hub core status, same clock
  input  wire logic [1:0]         power_state,
  input  wire logic [6:0]         attach_sensed,
  input  wire logic [6:0]         port_dcp,
  // pins
  input  wire logic               dynamic_charge_disable_n,
  output logic      [6:0]         port_power_control_pin_out,
  output logic      [6:0]         port_power_control_pin_oe,
  input  wire logic [6:0]         port_overcurrent_sense_pin_in,
  output logic      [6:0]         port_overcurrent_sense_pin_out,
  output logic      [6:0]         port_overcurrent_sense_pin_oe,
  // toward the analog front end and the hub functions
  output cpc_pkg::cpc_drive_t     drive,
  output cpc_pkg::cpc_ident_t     ident,
  output logic      [6:0]         switch_managed,
  output logic                    gang_power_eff,
  output logic                    gang_ocs_eff
);

  typedef struct packed {
    cpc_pkg::cpc_main_e_t st;
    logic [6:0]           chg_en;
    logic [6:0]           legacy;
    logic [6:0]           sig2a;
    logic [4:0]           pwr_cfg;
    logic [6:0]           port_pwr;
    logic [6:0]           nonrem;
    logic [15:0]          vid;
    logic [15:0]          pid2;
    logic [15:0]          pid3;
    logic [15:0]          did;
    logic [31:0]          rdata;
    logic                 err;
    logic [2:0]           idx;
    logic [6:0]           present;
    logic                 probed;
    logic                 start;
    logic [7:0]           dyn_sync;
    logic [13:0]          ocs_sync;
    cpc_pkg::cpc_drive_t  drv;
  } cpc_top_state_t;

  cpc_top_state_t r;
  cpc_top_state_t next_r;

  cpc_pkg::cpc_apb_req_t req;
  logic        smb_mode;
  logic [1:0]  pair;
  logic        any_chg;
  logic        dyn_n;
  logic        alert_n;
  logic        chg_allow;
  logic [6:0]  ocs_s;
  logic [6:0]  chg;
  logic        smb_busy;
  logic        smb_done;
  logic        smb_acked;
  logic        scl_oe;
  logic        sda_oe;
  logic        sda_in;
  logic [6:0]  pair_mask;

  // zero-extend a seven-port field to a bus word
  function automatic logic [31:0] cpc_word7(input logic [6:0] v);
    cpc_word7 = {25'h0000000, v};
  endfunction

  // one-hot port mask from a port index
  function automatic logic [6:0] cpc_port_bit(input logic [2:0] i);
    cpc_port_bit = 7'(8'h01 << i);
  endfunction

  assign req       = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign smb_mode  = r.pwr_cfg[`CPC_CFG_SMB];
  // two pair bits reach ports 1-4 only, so no other pair can be chosen
  assign pair      = r.pwr_cfg[`CPC_CFG_PAIR_HI:`CPC_CFG_PAIR_LO]; // RULE15
  assign pair_mask = smb_mode ? cpc_port_bit({1'b0, pair}) : 7'h00;
  assign any_chg   = |r.chg_en;
  assign ocs_s     = r.ocs_sync[13:7];
  assign sda_in    = ocs_s[pair];

  // the disable pin becomes the switch alert in smbus mode
  assign dyn_n     = r.dyn_sync[1];
  assign alert_n   = smb_mode ? dyn_n : 1'b1; // RULE4
  // with managed switches the pin no longer gates charging
  assign chg_allow = smb_mode | dyn_n; // RULE10 RULE11

  // per-port charging: power state decides how much the attach sense counts
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (power_state == `CPC_PS_S0 || power_state == `CPC_PS_S3) begin
        chg[i] = r.chg_en[i] & chg_allow; // RULE21
      end else begin
        // off states keep charging only for a sensed attached device
        chg[i] = r.chg_en[i] & chg_allow & attach_sensed[i]; // RULE21
      end
    end
  end

  // apb decode, probe sequencer and charging drive
  always_comb begin
    next_r          = r;
    next_r.start    = 1'b0;
    next_r.dyn_sync = {r.dyn_sync[6:0], dynamic_charge_disable_n};
    next_r.ocs_sync = {r.ocs_sync[6:0], port_overcurrent_sense_pin_in};

    // setup phase: writes land, read data is captured for the access phase
    if (req.psel && !req.penable) begin
      next_r.err = 1'b0;
      if (req.pwrite) begin
        unique case (req.paddr)
          `CPC_REG_CHG_EN:   next_r.chg_en   = req.pwdata[6:0];
          `CPC_REG_LEGACY:   next_r.legacy   = req.pwdata[6:0];
          `CPC_REG_SIG2A:    next_r.sig2a    = req.pwdata[6:0];
          `CPC_REG_PWR_CFG:  next_r.pwr_cfg  = req.pwdata[4:0];
          `CPC_REG_PORT_PWR: next_r.port_pwr = req.pwdata[6:0];
          `CPC_REG_NONREM:   next_r.nonrem   = req.pwdata[6:0];
          `CPC_REG_VID:      next_r.vid      = req.pwdata[15:0];
          `CPC_REG_PID:      {next_r.pid3, next_r.pid2} = req.pwdata;
          `CPC_REG_DID:      next_r.did      = req.pwdata[15:0];
          `CPC_REG_STATUS:   next_r.err      = 1'b1;
          default:           next_r.err      = 1'b1;
        endcase
        next_r.rdata = 32'h00000000;
      end else begin
        unique case (req.paddr)
          `CPC_REG_CHG_EN:   next_r.rdata = cpc_word7(r.chg_en);
          `CPC_REG_LEGACY:   next_r.rdata = cpc_word7(r.legacy);
          `CPC_REG_SIG2A:    next_r.rdata = cpc_word7(r.sig2a);
          `CPC_REG_PWR_CFG:  next_r.rdata = {27'h0000000, r.pwr_cfg};
          `CPC_REG_PORT_PWR: next_r.rdata = cpc_word7(r.port_pwr);
          `CPC_REG_NONREM:   next_r.rdata = cpc_word7(r.nonrem);
          `CPC_REG_VID:      next_r.rdata = {16'h0000, r.vid};
          `CPC_REG_PID:      next_r.rdata = {r.pid3, r.pid2};
          `CPC_REG_DID:      next_r.rdata = {16'h0000, r.did};
          `CPC_REG_STATUS:   next_r.rdata = {12'h000, ocs_s & ~pair_mask, gang_power_eff | gang_ocs_eff ? 1'b0 :
                                             (r.pwr_cfg[`CPC_CFG_GANG_PWR] | r.pwr_cfg[`CPC_CFG_GANG_OCS]) & any_chg,
                                             |r.nonrem, alert_n, ~chg_allow, r.probed,
                                             (r.st != cpc_pkg::CPC_M_IDLE) | smb_busy, r.present};
          default: begin
            next_r.rdata = 32'h00000000;
            next_r.err   = 1'b1;
          end
        endcase
      end
    end

    // probe every charging port's switch once smbus mode is on
    unique case (r.st)
      cpc_pkg::CPC_M_IDLE: begin
        if (smb_mode && !r.probed) begin
          next_r.st  = cpc_pkg::CPC_M_PROBE; // RULE5
          next_r.idx = 3'h0;
        end
      end
      cpc_pkg::CPC_M_PROBE: begin
        if (r.idx == `CPC_NPORT) begin
          next_r.st     = cpc_pkg::CPC_M_IDLE;
          next_r.probed = 1'b1;
        end else if (r.chg_en[r.idx]) begin
          // non-charging ports are never addressed
          next_r.start = 1'b1; // RULE2 RULE5
          next_r.st    = cpc_pkg::CPC_M_WAIT;
        end else begin
          next_r.present[r.idx] = 1'b0; // RULE2
          next_r.idx            = r.idx + 3'h1;
        end
      end
      cpc_pkg::CPC_M_WAIT: begin
        if (smb_done) begin
          next_r.present[r.idx] = smb_acked; // RULE5
          next_r.idx            = r.idx + 3'h1;
          next_r.st             = cpc_pkg::CPC_M_PROBE;
        end
      end
      default: next_r.st = cpc_pkg::CPC_M_IDLE;
    endcase
    // leaving smbus mode forgets the switches so a return reprobes
    if (!smb_mode && r.st == cpc_pkg::CPC_M_IDLE) begin
      next_r.present = 7'h00;
      next_r.probed  = 1'b0;
    end

    // d+/d- signalling is always made here, whatever switch powers the port
    for (int i = 0; i < 7; i++) begin
      next_r.drv.bc12_en[i]      = chg[i] & ~r.legacy[i]; // RULE6 RULE7
      next_r.drv.sig_en[i]       = chg[i] & ~r.legacy[i] & port_dcp[i]; // RULE7 RULE8 RULE14
      next_r.drv.sig_2a[i]       = chg[i] & ~r.legacy[i] & port_dcp[i] & r.sig2a[i]; // RULE13 RULE14
      next_r.drv.short_emul[i]   = chg[i] & ~r.legacy[i] & port_dcp[i]; // RULE8
      next_r.drv.legacy_drive[i] = chg[i] & r.legacy[i] & port_dcp[i]; // RULE9 RULE14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r      <= '0;
      r.st   <= cpc_pkg::CPC_M_IDLE;
      r.vid  <= `CPC_RST_VID;
      r.pid2 <= `CPC_RST_PID2;
      r.pid3 <= `CPC_RST_PID3;
      r.did  <= `CPC_RST_DID;
      // disable pin idles high, so reset does not fake a disable
      r.dyn_sync <= 8'hFF;
      // sense pins idle high too, so no false overcurrent right after reset
      r.ocs_sync <= '1;
    end else begin
      r <= next_r;
    end
  end

  // switch address is base plus port index
  cpc_smb_probe u_smb (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (r.start),
    .addr    (7'(`CPC_SW_ADDR_BASE + {4'h0, r.idx})),
    .busy    (smb_busy),
    .done    (smb_done),
    .acked   (smb_acked),
    .sda_in  (sda_in),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe)
  );

  // selected pair becomes scl on the power pin and sda on the sense pin
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pair_mask[i]) begin
        port_power_control_pin_out[i]     = 1'b0; // RULE3
        port_power_control_pin_oe[i]      = scl_oe; // RULE3
        port_overcurrent_sense_pin_out[i] = 1'b0;
        port_overcurrent_sense_pin_oe[i]  = sda_oe; // RULE3
      end else begin
        port_power_control_pin_out[i]     = r.port_pwr[i];
        port_power_control_pin_oe[i]      = 1'b1;
        port_overcurrent_sense_pin_out[i] = 1'b0;
        port_overcurrent_sense_pin_oe[i]  = 1'b0;
      end
    end
  end

  // gang requests are refused while any port charges
  assign gang_power_eff = r.pwr_cfg[`CPC_CFG_GANG_PWR] & ~any_chg; // RULE1 RULE12
  assign gang_ocs_eff   = r.pwr_cfg[`CPC_CFG_GANG_OCS] & ~any_chg; // RULE1 RULE12
  assign switch_managed = r.present & r.chg_en & {7{smb_mode}}; // RULE2

  // identity shared or split between the two hub functions
  assign ident.vid      = r.vid; // RULE16
  assign ident.pid2     = r.pid2; // RULE17
  assign ident.pid3     = r.pid3; // RULE17
  assign ident.did      = r.did; // RULE18
  assign ident.compound = |r.nonrem; // RULE19

  assign drive   = r.drv;
  assign prdata  = r.rdata;
  assign pslverr = penable & r.err;
  // every access finishes in its first access cycle
  assign pready  = 1'b1;

endmodule

// ===== sim/cpc_top_props.sv
// checker on the charging port control top ports
// assumes one sys_clk domain and a synchronous active high reset
`timescale 1ns/10ps
module cpc_top_props (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  // hub core status and pins
  input wire logic [1:0]          power_state,
  input wire logic [6:0]          attach_sensed,
  input wire logic [6:0]          port_dcp,
  input wire logic                dynamic_charge_disable_n,
  input wire logic [6:0]          port_power_control_pin_oe,
  input wire logic [6:0]          port_overcurrent_sense_pin_oe,
  // charging drive and gang outputs
  input wire cpc_pkg::cpc_drive_t drive,
  input wire logic                gang_power_eff,
  input wire logic                gang_ocs_eff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // gang flags lead the drive by one cycle, so look one cycle on
  AST_GANG_OFF: assert property (gang_power_eff || gang_ocs_eff |=>
    drive.bc12_en == 7'h00 && drive.legacy_drive == 7'h00) else $error("gang with charging");
  AST_SHORT_SIG: assert property (drive.short_emul == drive.sig_en) else $error("short emul split");
  AST_SIG_DCP: assert property ((drive.sig_en & ~$past(port_dcp)) == 7'h00) else $error("sig off dcp");
  AST_LEG_DCP: assert property ((drive.legacy_drive & ~$past(port_dcp)) == 7'h00) else $error("legacy off dcp");
  AST_SIG2A: assert property ((drive.sig_2a & ~drive.sig_en) == 7'h00) else $error("2a without sig");
  AST_LEG_EXCL: assert property ((drive.legacy_drive & (drive.sig_en | drive.bc12_en)) == 7'h00)
    else $error("legacy mixed");
  // pin must settle through the synchroniser before charging stops
  AST_DYN_OFF: assert property ((!dynamic_charge_disable_n && &port_power_control_pin_oe) [*4]
    |=> drive == 35'h0) else $error("charging while disabled");
  AST_ATTACH: assert property ($past(power_state[1]) |->
    ((drive.bc12_en | drive.legacy_drive) & ~$past(attach_sensed)) == 7'h00) else $error("deep sleep no attach");
  AST_ONE_SDA: assert property ($onehot0(port_overcurrent_sense_pin_oe)) else $error("two data pins");

  // main scenarios reached
  cover property (drive.sig_2a != 7'h00);
  cover property (port_overcurrent_sense_pin_oe != 7'h00);
  cover property (gang_power_eff && gang_ocs_eff);
endmodule

bind cpc_top cpc_top_props cpc_top_props_inst (
  .sys_clk                       (sys_clk),
  .sys_rst                       (sys_rst),
  .power_state                   (power_state),
  .attach_sensed                 (attach_sensed),
  .port_dcp                      (port_dcp),
  .dynamic_charge_disable_n      (dynamic_charge_disable_n),
  .port_power_control_pin_oe     (port_power_control_pin_oe),
  .port_overcurrent_sense_pin_oe (port_overcurrent_sense_pin_oe),
  .drive                         (drive),
  .gang_power_eff                (gang_power_eff),
  .gang_ocs_eff                  (gang_ocs_eff)
);

// ===== sim/cpc_switch_model.sv
// behavioural managed power switch on the smbus pair
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/10ps
module cpc_switch_model #(
  parameter logic [6:0] MY_ADDR = 7'h30
) (
  // resolved bus lines
  input  wire logic  scl,
  input  wire logic  sda,
  // data pull and log of addressed slots
  output logic       sda_pull,
  output logic [13:0] seen
);
  int unsigned nbit;
  logic [7:0]  shreg;

  initial begin
    sda_pull = 1'b0;
    seen     = 14'h0000;
    nbit     = 0;
    shreg    = 8'h00;
  end

  // start: data falls while clock high
  always @(negedge sda) begin
    if (scl) begin
      nbit = 0;
    end
  end

  // address msb first, then the write bit
  always @(posedge scl) begin
    shreg = {shreg[6:0], sda};
    nbit  = nbit + 1;
  end

  // ack held over the ninth clock, only for our own slot
  always @(negedge scl) begin
    if (nbit == 8) begin
      seen     <= {seen[6:0], shreg[7:1]};
      sda_pull <= (shreg[7:1] == MY_ADDR);
    end else begin
      sda_pull <= 1'b0;
    end
  end
endmodule

// ===== sim/cpc_top_tb.sv
// self-checking bench for the charging port control block
// assumes the switch model on port 2 pins and a 100 MHz sys_clk
`timescale 1ns/10ps
`include "cpc_consts.svh"
module cpc_top_tb;
  localparam int PAIR = 1;
  logic                sys_clk       = 1'b0;
  logic                sys_rst       = 1'b1;
  logic                psel          = 1'b0;
  logic                penable       = 1'b0;
  logic                pwrite        = 1'b0;
  logic [7:0]          paddr         = 8'h00;
  logic [31:0]         pwdata        = 32'h0;
  logic [1:0]          power_state   = 2'h0;
  logic [6:0]          attach_sensed = 7'h00;
  logic [6:0]          port_dcp      = 7'h00;
  logic                dyn_n         = 1'b1;
  logic [31:0]         prdata, rdat;
  logic                pready, pslverr, rerr, gang_p, gang_o, scl, sda, sda_pull;
  logic [6:0]          pwr_out, pwr_oe, ocs_in, ocs_out, ocs_oe, managed;
  logic [13:0]         seen;
  cpc_pkg::cpc_drive_t drive;
  cpc_pkg::cpc_ident_t ident;
  int                  failures      = 0;
  int                  comparisons   = 0;
  int                  cycles        = 0;
  int                  n;

  always #5 sys_clk = ~sys_clk;

  // pull-ups on the pair; other sense pins read no overcurrent
  assign scl = pwr_oe[PAIR] ? pwr_out[PAIR] : 1'b1;
  assign sda = ~ocs_oe[PAIR] & ~sda_pull;
  always_comb begin
    ocs_in       = 7'h7F;
    ocs_in[PAIR] = sda;
  end

  cpc_top cpc_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_state(power_state), .attach_sensed(attach_sensed),
    .port_dcp(port_dcp), .dynamic_charge_disable_n(dyn_n), .port_power_control_pin_out(pwr_out),
    .port_power_control_pin_oe(pwr_oe), .port_overcurrent_sense_pin_in(ocs_in),
    .port_overcurrent_sense_pin_out(ocs_out), .port_overcurrent_sense_pin_oe(ocs_oe),
    .drive(drive), .ident(ident), .switch_managed(managed), .gang_power_eff(gang_p),
    .gang_ocs_eff(gang_o));

  cpc_switch_model cpc_switch_model_inst (.scl(scl), .sda(sda), .sda_pull(sda_pull), .seen(seen));

  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard well above the two-port probe time
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle cycle after keeps drives one per step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_ident();
    xfer(1'b0, `CPC_REG_VID, 32'h0);
    chk(rdat, {16'h0000, `CPC_RST_VID});
    xfer(1'b0, `CPC_REG_PID, 32'h0);
    chk(rdat, {`CPC_RST_PID3, `CPC_RST_PID2});
    xfer(1'b0, `CPC_REG_DID, 32'h0);
    chk(rdat, {16'h0000, `CPC_RST_DID});
    xfer(1'b1, `CPC_REG_VID, 32'h0000_BEEF);
    xfer(1'b1, `CPC_REG_PID, 32'h3333_2222);
    xfer(1'b1, `CPC_REG_DID, 32'h0000_0042);
    chk({ident.vid, ident.did}, 32'hBEEF_0042);
    chk({ident.pid3, ident.pid2}, 32'h3333_2222);
    xfer(1'b1, `CPC_REG_NONREM, 32'h0000_0040);
    chk({31'h0, ident.compound}, 32'h1);
    xfer(1'b1, `CPC_REG_NONREM, 32'h0);
    chk({31'h0, ident.compound}, 32'h0);
    xfer(1'b1, `CPC_REG_PORT_PWR, 32'h0000_0055);
    chk({pwr_out, ocs_out, pwr_oe}, {11'h000, 7'h55, 7'h00, 7'h7F});
    xfer(1'b0, 8'h28, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    xfer(1'b1, `CPC_REG_STATUS, 32'hFFFF_FFFF);
    chk({31'h0, rerr}, 32'h1);
  endtask

  task automatic t_modes();
    port_dcp <= 7'h0F;
    xfer(1'b1, `CPC_REG_LEGACY, 32'h0C);
    xfer(1'b1, `CPC_REG_SIG2A, 32'h05);
    xfer(1'b1, `CPC_REG_PWR_CFG, 32'h18);
    xfer(1'b1, `CPC_REG_CHG_EN, 32'h7F);
    chk({drive.bc12_en, drive.sig_en, drive.sig_2a, drive.short_emul}, {4'h0, 7'h73, 7'h03, 7'h01, 7'h03});
    chk(drive.legacy_drive, 7'h0C);
    chk({gang_p, gang_o}, 2'h0);
    xfer(1'b0, `CPC_REG_STATUS, 32'h0);
    chk(rdat[12], 1'b1);
    // ports fall back from dedicated to communicating
    port_dcp <= 7'h00;
    repeat (2) @(posedge sys_clk);
    chk({drive.sig_en, drive.legacy_drive, drive.bc12_en}, 21'h73);
    dyn_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk({31'h0, |drive}, 32'h0);
    dyn_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(drive.bc12_en, 7'h73);
    power_state   <= 2'h2;
    attach_sensed <= 7'h05;
    repeat (3) @(posedge sys_clk);
    chk(drive.bc12_en, 7'h01);
    power_state   <= 2'h0;
    attach_sensed <= 7'h00;
    xfer(1'b1, `CPC_REG_CHG_EN, 32'h0);
    chk({gang_p, gang_o}, 2'h3);
    xfer(1'b1, `CPC_REG_PWR_CFG, 32'h0);
    xfer(1'b1, `CPC_REG_LEGACY, 32'h0);
  endtask

  task automatic t_probe();
    xfer(1'b1, `CPC_REG_CHG_EN, 32'h05);
    xfer(1'b1, `CPC_REG_PWR_CFG, 32'h03);
    n = 0;
    do begin
      repeat (200) @(posedge sys_clk);
      xfer(1'b0, `CPC_REG_STATUS, 32'h0);
      n++;
    end while (rdat[8] !== 1'b1 && n < 200);
    chk(rdat[8:0], 9'h101);
    chk(seen, 14'h1832);
    chk(managed, 7'h01);
    chk(pwr_oe, 7'h7D);
    dyn_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    xfer(1'b0, `CPC_REG_STATUS, 32'h0);
    chk(rdat[10], 1'b0);
    chk(drive.bc12_en, 7'h05);
    dyn_n <= 1'b1;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_ident();
    t_modes();
    t_probe();
    tally_and_finish();
  end
endmodule
